// ===== verilog/dsw_dac_port.sv
// Purpose: Device end, serial write port of a string DAC
// Assumes: Link pins sampled by clk, two-flop synchronised
// Notes: WIDE selects 24-bit frame, else 16-bit with RES bits
// Function
// - Master lowers frame select before clocking
// - Shift data on falling clock edges
// - Execute frame on final falling edge
// - Select may stay low after frame
// - Fresh select fall starts next frame
// - Master parks select low when idle
// - Serial clock at most 30 MHz
// - Data code is straight binary
// - Early select rise discards frame
// - Narrow frame: two mode, then data
// - Wide frame: six ignored, mode, data
// - Mode codes; DAC code kept in power-down; here dac_code loads on every frame, any mode
`timescale 1ns/1ps
`default_nettype none
module dsw_dac_port #(
    parameter int WIDE = 1,
    parameter int RES = 16
) (
    // System
    input wire logic clk,
    input wire logic rst,
    // Link
    dsw_if.dac link,
    // User side
    output logic [15:0] dac_code,
    output logic [1:0] pd_mode,
    output logic update
);
    localparam int FBITS = (WIDE != 0) ? dsw_pkg::WIDE_BITS : dsw_pkg::NARROW_BITS;
    localparam int MPOS = (WIDE != 0) ? dsw_pkg::WIDE_MODE_POS : dsw_pkg::NARROW_MODE_POS;
    localparam int DBITS = (WIDE != 0) ? dsw_pkg::WIDE_DATA_BITS : RES;
    localparam int DLSB = (WIDE != 0) ? 0 : (dsw_pkg::NARROW_MODE_POS - RES);
    localparam logic [4:0] LAST = 5'(FBITS - 1);

    // ------------------------------------------------------------
    // Synchronisers
    // ------------------------------------------------------------
    // Pin order: 0 select, 1 serial clock, 2 data
    localparam int NPIN = 3;
    localparam logic [2:0] PIN_IDLE = 3'h3;
    wire [2:0] pin_raw;
    wire [2:0] pin_s;
    logic [1:0] pin_d_reg;
    assign pin_raw = {link.sdin, link.sclk, link.sync_n};
    genvar gi;
    generate
        for (gi = 0; gi < NPIN; gi = gi + 1) begin : g_sync
            logic s1_reg;
            logic s2_reg;
            always_ff @(posedge clk) begin
                if (rst) begin
                    s1_reg <= PIN_IDLE[gi];
                    s2_reg <= PIN_IDLE[gi];
                end else begin
                    s1_reg <= pin_raw[gi];
                    s2_reg <= s1_reg;
                end
            end
            assign pin_s[gi] = s2_reg;
        end
    endgenerate

    // Edge detect on synchronised select and clock
    always_ff @(posedge clk) begin
        if (rst) begin
            pin_d_reg <= 2'h3;
        end else begin
            pin_d_reg <= pin_s[1:0];
        end
    end
    wire sync_lo = ~pin_s[0];
    wire sync_fall = pin_d_reg[0] & ~pin_s[0];
    wire sclk_fall = pin_d_reg[1] & ~pin_s[1];
    wire sdin_s = pin_s[2];

    // ------------------------------------------------------------
    // Frame state
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        DSW_IDLE = 3'h1,
        DSW_SHIFT = 3'h2,
        DSW_DONE = 3'h4
    } dsw_state_t;
    dsw_state_t state_reg;
    dsw_state_t state_next;
    logic [23:0] shift_reg;
    logic [23:0] shift_next;
    logic [4:0] cnt_reg;
    logic [4:0] cnt_next;
    logic [15:0] code_reg;
    logic [15:0] code_next;
    logic [1:0] mode_reg;
    logic [1:0] mode_next;
    logic upd_reg;
    logic upd_next;

    // ------------------------------------------------------------
    // Field decode
    // ------------------------------------------------------------
    // MSB first shift
    wire [23:0] shifted = {shift_reg[22:0], sdin_s};
    wire last_edge = sclk_fall && (cnt_reg == LAST);
    wire [1:0] new_mode = shifted[MPOS+1:MPOS];
    wire [15:0] new_code = 16'(shifted[DLSB+DBITS-1:DLSB]);

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        shift_next = shift_reg;
        cnt_next = cnt_reg;
        code_next = code_reg;
        mode_next = mode_reg;
        upd_next = 1'b0;
        case (state_reg)
            DSW_IDLE: begin
                if (sync_fall) begin
                    state_next = DSW_SHIFT;
                    shift_next = 24'h000000;
                    cnt_next = 5'h00;
                end
            end
            DSW_SHIFT: begin
                if (!sync_lo) begin
                    state_next = DSW_IDLE;
                    shift_next = 24'h000000;
                    cnt_next = 5'h00;
                end else if (last_edge) begin
                    state_next = DSW_DONE;
                    shift_next = shifted;
                    code_next = new_code;
                    mode_next = new_mode;
                    upd_next = 1'b1;
                end else if (sclk_fall) begin
                    shift_next = shifted;
                    cnt_next = cnt_reg + 5'h01;
                end
            end
            DSW_DONE: begin
                if (!sync_lo) begin
                    state_next = DSW_IDLE;
                    cnt_next = 5'h00;
                end
            end
            default: begin
                state_next = DSW_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Frame registers
    // ------------------------------------------------------------
    // Frame state and falling-edge count
    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= DSW_IDLE;
            cnt_reg <= 5'h00;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
        end
    end

    // Shift register, cleared on start and abort
    always_ff @(posedge clk) begin
        if (rst) begin
            shift_reg <= 24'h000000;
        end else begin
            shift_reg <= shift_next;
        end
    end

    // ------------------------------------------------------------
    // Output registers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            code_reg <= dsw_pkg::CODE_RESET;
            mode_reg <= dsw_pkg::MODE_RESET;
            upd_reg <= 1'b0;
        end else begin
            code_reg <= code_next;
            mode_reg <= mode_next;
            upd_reg <= upd_next;
        end
    end

    // Outputs straight from flops
    assign dac_code = code_reg;
    assign pd_mode = mode_reg;
    assign update = upd_reg;
endmodule : dsw_dac_port
`default_nettype wire

// ===== verilog/dsw_pkg.sv
// Purpose: Shared constants for the serial DAC write port
// Assumes: 50 MHz system clock on both ends
// Notes: Frame layouts and mode codes
package dsw_pkg;
    // ------------------------------------------------------------
    // Frame layout
    // ------------------------------------------------------------
    localparam int NARROW_BITS = 16;
    localparam int WIDE_BITS = 24;
    localparam int NARROW_MODE_POS = 14;
    localparam int WIDE_MODE_POS = 16;
    localparam int WIDE_DATA_BITS = 16;
    localparam int CNT_W = 5;
    // ------------------------------------------------------------
    // Mode codes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        DSW_MODE_NORMAL = 2'h0,
        DSW_MODE_PD_1K = 2'h1,
        DSW_MODE_PD_100K = 2'h2,
        DSW_MODE_TRISTATE = 2'h3
    } dsw_mode_t;
    localparam logic [1:0] MODE_RESET = 2'h0;
    localparam logic [15:0] CODE_RESET = 16'h0000;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 50000000;
    localparam int SYNC_HIGH_NS = 33;
    localparam int SYNC_HIGH_CYC_RAW = (SYNC_HIGH_NS * (CLK_HZ / 1000000) + 999) / 1000;
    localparam int SYNC_HIGH_CYC = (SYNC_HIGH_CYC_RAW < 1) ? 1 : SYNC_HIGH_CYC_RAW;
    localparam int SCLK_MAX_HZ = 30000000;
    localparam int SCLK_HALF_DEFAULT = 4;
    localparam int HALF_W = 8;
    localparam int SYNC_LEAD_CYC = SYNC_HIGH_CYC + 1;
endpackage : dsw_pkg

// ===== verilog/dsw_if.sv
// Purpose: Three-wire link between master and DAC port
// Assumes: All wires driven by the master
// Notes: No clocking block
`timescale 1ns/1ps
`default_nettype none
interface dsw_if;
    logic sync_n;
    logic sclk;
    logic sdin;
    modport master (output sync_n, output sclk, output sdin);
    modport dac (input sync_n, input sclk, input sdin);
endinterface : dsw_if
`default_nettype wire

// ===== verilog/dsw_master.sv
// Purpose: Master end, writes frames to the DAC port
// Assumes: Frame bits prepared by the user, MSB at bit 23 for wide frames, bit 15 for narrow
// Notes: Serial clock made by a divider of clk
`timescale 1ns/1ps
`default_nettype none
module dsw_master #(
    parameter int WIDE = 1,
    parameter int HALF = dsw_pkg::SCLK_HALF_DEFAULT
) (
    // System
    input wire logic clk,
    input wire logic rst,
    // User side
    input wire logic start,
    input wire logic [23:0] frame,
    input wire logic abort,
    output logic busy,
    output logic done,
    // Link
    dsw_if.master link
);
    localparam int FBITS = (WIDE != 0) ? dsw_pkg::WIDE_BITS : dsw_pkg::NARROW_BITS;
    localparam logic [4:0] NBITS = 5'(FBITS);
    // half period keeps sclk within limit
    localparam logic [7:0] HALF_C = 8'(HALF);
    localparam logic [7:0] LEAD_C = 8'(dsw_pkg::SYNC_LEAD_CYC);

    typedef enum logic [3:0] {
        DSM_PARK = 4'h1,
        DSM_HIGH = 4'h2,
        DSM_BIT = 4'h4,
        DSM_END = 4'h8
    } dsm_state_t;
    dsm_state_t state_reg, state_next;
    logic [23:0] sh_reg, sh_next;
    logic [4:0] bit_reg, bit_next;
    logic [7:0] tim_reg, tim_next;
    logic sync_reg, sync_next, sclk_reg, sclk_next, done_reg, done_next;
    logic busy_reg;
    wire tdone = (tim_reg == 8'h00);

    always_comb begin
        state_next = state_reg;
        sh_next = sh_reg;
        bit_next = bit_reg;
        tim_next = tdone ? tim_reg : tim_reg - 8'h01;
        sync_next = sync_reg;
        sclk_next = sclk_reg;
        done_next = 1'b0;
        case (state_reg)
            DSM_PARK: begin
                sync_next = 1'b0;
                if (start) begin
                    state_next = DSM_HIGH;
                    sync_next = 1'b1;
                    sh_next = frame;
                    tim_next = LEAD_C;
                end
            end
            DSM_HIGH: begin
                if (tdone) begin
                    state_next = DSM_BIT;
                    sync_next = 1'b0;
                    bit_next = NBITS;
                    tim_next = HALF_C;
                end
            end
            DSM_BIT: begin
                if (abort) begin
                    state_next = DSM_END;
                    sync_next = 1'b1;
                    sclk_next = 1'b1;
                    tim_next = LEAD_C;
                end else if (tdone) begin
                    tim_next = HALF_C;
                    sclk_next = ~sclk_reg;
                    if (!sclk_reg) begin
                        sh_next = {sh_reg[22:0], 1'b0};
                        if (bit_reg == 5'h00) begin
                            state_next = DSM_END;
                        end
                    end else begin
                        bit_next = bit_reg - 5'h01;
                    end
                end
            end
            DSM_END: begin
                if (tdone) begin
                    state_next = DSM_PARK;
                    sync_next = 1'b0;
                    done_next = 1'b1;
                end
            end
            default: begin
                state_next = DSM_PARK;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= DSM_PARK;
            sh_reg <= 24'h000000;
            bit_reg <= 5'h00;
            tim_reg <= 8'h00;
            sync_reg <= 1'b1;
            sclk_reg <= 1'b1;
            done_reg <= 1'b0;
            busy_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            sh_reg <= sh_next;
            bit_reg <= bit_next;
            tim_reg <= tim_next;
            sync_reg <= sync_next;
            sclk_reg <= sclk_next;
            done_reg <= done_next;
            busy_reg <= (state_next != DSM_PARK);
        end
    end

    wire [4:0] msb_idx = 5'(FBITS - 1);
    assign link.sync_n = sync_reg;
    assign link.sclk = sclk_reg;
    assign link.sdin = sh_reg[msb_idx];
    assign busy = busy_reg;
    assign done = done_reg;
endmodule : dsw_master
`default_nettype wire

// ===== tb/dsw_link_props.sv
// Purpose: Link and output checks for the serial DAC write port
// Assumes: Wide frame, serial clock made from clk by the master
// Notes: Instantiated beside the link interface
`timescale 1ns/1ps
`default_nettype none
module dsw_link_props (
    // System
    input wire logic clk,
    input wire logic rst,
    // Link
    input wire logic sync_n,
    input wire logic sclk,
    input wire logic sdin,
    // Device and master outputs
    input wire logic [15:0] dac_code,
    input wire logic [1:0] pd_mode,
    input wire logic update,
    input wire logic busy
);
    // ------------------------------------------------------------
    // Helper logic
    // ------------------------------------------------------------
    logic sclk_reg;
    logic [4:0] fall_cnt_reg;
    logic [3:0] high_cnt_reg;
    logic [23:0] shift_reg;
    wire logic sclk_fall = sclk_reg & ~sclk & ~sync_n;
    wire logic high_full = (high_cnt_reg == 4'hF);
    always_ff @(posedge clk) begin
        sclk_reg <= sclk;
        high_cnt_reg <= sync_n ? (high_cnt_reg + {3'h0, ~high_full}) : 4'h0;
        fall_cnt_reg <= sync_n ? 5'h0 : (fall_cnt_reg + {4'h0, sclk_fall});
        if (sclk_fall) begin
            shift_reg <= {shift_reg[22:0], sdin};
        end
    end
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    chk_start_idle: assert property ($fell(sync_n) |-> sclk)
        else $error("serial clock low when frame select fell");
    chk_lead_time: assert property ($fell(sync_n) && busy |-> high_cnt_reg >= 4'h3)
        else $error("frame select high too short");
    chk_sclk_phase: assert property ($changed(sclk) |=> $stable(sclk))
        else $error("serial clock phase shorter than two cycles");
    chk_frame_exec: assert property (sclk_fall && fall_cnt_reg == 5'h17 |-> ##[2:8] update)
        else $error("no update after final falling edge");
    chk_abort_quiet: assert property (update |-> fall_cnt_reg == 5'h18)
        else $error("update without a complete frame");
    chk_outputs_hold: assert property ($changed(dac_code) || $changed(pd_mode) |-> update)
        else $error("outputs changed without update");
    chk_code_field: assert property (update |-> dac_code == shift_reg[15:0])
        else $error("code differs from last sixteen bits");
    chk_mode_field: assert property (update |-> pd_mode == shift_reg[17:16])
        else $error("mode differs from mode field");
    cover_frame: cover property (update);
    cover_tristate: cover property (update && pd_mode == 2'h3);
    cover_abort: cover property ($rose(sync_n) && fall_cnt_reg != 5'h0 && fall_cnt_reg < 5'h18);
endmodule : dsw_link_props
`default_nettype wire

// ===== tb/dac_serial_write_port_bench.sv
// Purpose: Self-checking bench, master and device joined by the link
// Assumes: Wide pair at half period 4, narrow 12-bit pair at 3
// Notes: Wire bits captured on serial clock falls
`timescale 1ns/1ps
`default_nettype none
module dac_serial_write_port_bench;
    // ------------------------------------------------------------
    // Signals and instances
    // ------------------------------------------------------------
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic start = 1'b0;
    logic abort = 1'b0;
    logic [23:0] frame = 24'h0;
    logic busy, done, update;
    logic [15:0] dac_code;
    logic [1:0] pd_mode;
    logic [23:0] wire_sh = 24'h0;
    int errors = 0;
    int n_tests = 0;
    int upd_cnt = 0;
    int n_upd_cnt = 0;
    logic n_start = 1'b0;
    logic n_abort = 1'b0;
    logic [23:0] n_frame = 24'h0;
    logic n_busy, n_done, n_update;
    logic [15:0] n_code;
    logic [1:0] n_mode;
    dsw_if link_if ();
    dsw_if nar_if ();
    dsw_master #(.WIDE(1), .HALF(4)) dsw_master_inst (.clk(clk), .rst(rst), .start(start),
        .frame(frame), .abort(abort), .busy(busy), .done(done), .link(link_if));
    dsw_dac_port #(.WIDE(1), .RES(16)) dsw_dac_port_inst (.clk(clk), .rst(rst), .link(link_if),
        .dac_code(dac_code), .pd_mode(pd_mode), .update(update));
    dsw_link_props dsw_link_props_inst (.clk(clk), .rst(rst), .sync_n(link_if.sync_n),
        .sclk(link_if.sclk), .sdin(link_if.sdin), .dac_code(dac_code), .pd_mode(pd_mode),
        .update(update), .busy(busy));
    dsw_master #(.WIDE(0), .HALF(3)) dsw_master_nar_inst (.clk(clk), .rst(rst), .start(n_start),
        .frame(n_frame), .abort(n_abort), .busy(n_busy), .done(n_done), .link(nar_if));
    dsw_dac_port #(.WIDE(0), .RES(12)) dsw_dac_port_nar_inst (.clk(clk), .rst(rst),
        .link(nar_if), .dac_code(n_code), .pd_mode(n_mode), .update(n_update));
    always @(negedge link_if.sclk) begin
        if (link_if.sync_n === 1'b0) begin
            wire_sh <= {wire_sh[22:0], link_if.sdin};
        end
    end
    always @(posedge clk) begin
        if (update === 1'b1) begin
            upd_cnt <= upd_cnt + 1;
        end
        if (n_update === 1'b1) begin
            n_upd_cnt <= n_upd_cnt + 1;
        end
    end
    initial begin
        forever #10 clk = ~clk;
    end
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check
    task automatic end_sim();
        $display("checks %0d, mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_sim
    task automatic send(input logic [23:0] f, input logic stop);
        int i;
        frame = f;
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
        if (stop) begin
            repeat (100) @(negedge clk);
            abort = 1'b1;
        end
        for (i = 0; i < 1000 && done !== 1'b1; i++) begin
            @(negedge clk);
        end
        if (done !== 1'b1) begin
            errors++;
            end_sim();
        end
        abort = 1'b0;
        repeat (4) @(negedge clk);
        check({23'h0, busy}, 24'h0);
    endtask : send
    task automatic sc_modes();
        logic [15:0] codes [4] = '{16'hFFFF, 16'h0000, 16'h8000, 16'h7FFF};
        int n;
        for (int m = 0; m < 4; m++) begin
            n = upd_cnt;
            send({6'h3F, m[1:0], codes[m]}, 1'b0);
            check(wire_sh, {6'h3F, m[1:0], codes[m]});
            check({8'h0, dac_code}, {8'h0, codes[m]});
            check({22'h0, pd_mode}, {22'h0, m[1:0]});
            check(24'(upd_cnt - n), 24'h1);
            check({22'h0, link_if.sclk, link_if.sync_n}, 24'h2);
        end
    endtask : sc_modes
    task automatic sc_abort();
        int n;
        n = upd_cnt;
        send(24'h011234, 1'b1);
        check(24'(upd_cnt - n), 24'h0);
        check({6'h0, pd_mode, dac_code}, 24'h037FFF);
        send(24'h025A5A, 1'b0);
        check({6'h0, pd_mode, dac_code}, 24'h025A5A);
        check(24'(upd_cnt - n), 24'h1);
    endtask : sc_abort
    task automatic send_nar(input logic [15:0] f, input logic stop);
        int i;
        n_frame = {8'h00, f};
        n_start = 1'b1;
        @(negedge clk);
        n_start = 1'b0;
        if (stop) begin
            repeat (40) @(negedge clk);
            n_abort = 1'b1;
        end
        for (i = 0; i < 1000 && n_done !== 1'b1; i++) begin
            @(negedge clk);
        end
        if (n_done !== 1'b1) begin
            errors++;
            end_sim();
        end
        n_abort = 1'b0;
        repeat (4) @(negedge clk);
        check({23'h0, n_busy}, 24'h0);
    endtask : send_nar
    task automatic sc_narrow();
        int n;
        n = n_upd_cnt;
        send_nar(16'hB5A7, 1'b0);
        check({6'h0, n_mode, n_code}, 24'h020D69);
        send_nar(16'h4FFF, 1'b1);
        check({6'h0, n_mode, n_code}, 24'h020D69);
        check(24'(n_upd_cnt - n), 24'h1);
    endtask : sc_narrow
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (2) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        check({6'h0, pd_mode, dac_code}, 24'h0);
        sc_modes();
        sc_abort();
        sc_narrow();
        end_sim();
    end
endmodule : dac_serial_write_port_bench
`default_nettype wire
